// ---- hw/msd_map.svh ----
`ifndef MSD_MAP_SVH
`define MSD_MAP_SVH
// data space window limits
`define MSD_NVM_BASE    16'h0000
`define MSD_NVM_LAST    16'h01ff
`define MSD_RAM_BASE    16'h0200
`define MSD_RAM_LAST    16'h02ff
`define MSD_SPACE_BYTES 32'h00010000
// external cycle phase lengths in sys_clk cycles
`define MSD_ADDR_CYC    2
`define MSD_STRB_CYC    2
// level of the space select pin for program cycles
`define MSD_SEL_PROG    1'b1
`endif

// ---- hw/msd_memory_space_decoder.sv ----
`timescale 1ns/1ps
`include "msd_map.svh"
// Notes on behaviour
// [RL1] separate program and data spaces, each 64 KiB with 16-bit address
// [RL2] all program accesses, fetches too, go to external memory
// [RL3] data addresses 0..1FFh select on-chip nonvolatile memory
// [RL4] data addresses 200h..2FFh select on-chip RAM
// [RL5] external address: low byte muxed with data on one port, high byte other
// [RL6] drive program/data select for every external access
// [RL7] address strobe pulses low once per memory cycle; rise marks address valid
// [RL8] on-chip data access keeps data strobe high for whole cycle
// [RL9] direction low on memory writes, high otherwise
// [RL10] data addresses above RAM go external with program-style strobe sequence
module msd_memory_space_decoder (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // core request
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic        req_prog,
  input  wire logic        req_write,
  input  wire logic [15:0] req_addr,
  input  wire logic [7:0]  req_wdata,
  // core answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  // on-chip nonvolatile memory
  output logic             nvm_en,
  output logic             nvm_we,
  output logic [8:0]       nvm_addr,
  output logic [7:0]       nvm_wdata,
  input  wire logic [7:0]  nvm_rdata,
  // on-chip ram
  output logic             ram_en,
  output logic             ram_we,
  output logic [7:0]       ram_addr,
  output logic [7:0]       ram_wdata,
  input  wire logic [7:0]  ram_rdata,
  // external bus, port 0 muxed address/data
  input  wire logic [7:0]  ad_in,
  output logic [7:0]       ad_out,
  output logic [7:0]       ad_oe_n,
  // external bus, port 1 high address
  output logic [7:0]       addr_hi,
  // external bus strobes
  output logic             address_latch_strobe_n,
  output logic             transfer_strobe_n,
  output logic             rd_wr_n,
  output logic             prog_data_sel
);
  msd_pkg::msd_tgt_t   tgt;
  msd_pkg::msd_state_t state_ff;
  msd_pkg::msd_state_t nxt_state;
  msd_pkg::msd_tgt_t   tgt_ff;
  logic                write_ff;
  logic                prog_ff;
  logic [15:0]         addr_ff;
  logic [7:0]          wdata_ff;
  logic [1:0]          cnt_ff;
  logic [7:0]          ad_sync1_ff;
  logic [7:0]          ad_sync2_ff;
  logic                take;
  logic                phase_end;
  logic                nxt_write;
  logic                nxt_prog;
  logic [15:0]         nxt_addr;

  // full 16-bit address reaches every space
  msd_target_decode u_decode (
    .is_prog (req_prog),
    .addr    (req_addr),  // RL1
    .tgt     (tgt)
  );

  assign req_ready = (state_ff == msd_pkg::MSD_IDLE);
  assign take      = req_valid & req_ready;
  assign phase_end = (state_ff == msd_pkg::MSD_ADDR) ? (cnt_ff == 2'(`MSD_ADDR_CYC - 1))
                                                       : (cnt_ff == 2'(`MSD_STRB_CYC - 1));

  // request fields as they stand after this edge
  // pins switch with the take, not one cycle late with the old access
  assign nxt_write = take ? req_write : write_ff;
  assign nxt_prog  = take ? req_prog  : prog_ff;
  assign nxt_addr  = take ? req_addr  : addr_ff;

  // cycle sequencer
  // fixed phase lengths, no wait states from the far side
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      msd_pkg::MSD_IDLE: if (take) nxt_state = msd_pkg::MSD_ADDR;
      msd_pkg::MSD_ADDR: if (phase_end) nxt_state = msd_pkg::MSD_STRB;
      msd_pkg::MSD_STRB: if (phase_end) nxt_state = msd_pkg::MSD_DONE;
      msd_pkg::MSD_DONE: nxt_state = msd_pkg::MSD_IDLE;
      default:           nxt_state = msd_pkg::MSD_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= msd_pkg::MSD_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // phase counter
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= 2'h0;
    end else if (state_ff != nxt_state) begin
      cnt_ff <= 2'h0;
    end else if (state_ff != msd_pkg::MSD_IDLE) begin
      cnt_ff <= cnt_ff + 2'h1;
    end
  end

  // capture the request
  // held for the whole access so nothing moves mid-cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tgt_ff   <= msd_pkg::MSD_TGT_EXT;
      write_ff <= 1'b0;
      prog_ff  <= 1'b1;
      addr_ff  <= 16'h0000;
      wdata_ff <= 8'h00;
    end else if (take) begin
      tgt_ff   <= tgt;
      write_ff <= req_write;
      prog_ff  <= req_prog;
      addr_ff  <= req_addr;
      wdata_ff <= req_wdata;
    end
  end

  // external data input synchroniser
  // only the second stage feeds logic; the first may be metastable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ad_sync1_ff <= 8'h00;
      ad_sync2_ff <= 8'h00;
    end else begin
      ad_sync1_ff <= ad_in;
      ad_sync2_ff <= ad_sync1_ff;
    end
  end

  // external strobes, registered from the next state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      address_latch_strobe_n <= 1'b1;
      transfer_strobe_n      <= 1'b1;
    end else begin
      // low for the address phase, rises on the same edge that starts the strobe phase
      address_latch_strobe_n <= !(nxt_state == msd_pkg::MSD_ADDR); // RL7
      transfer_strobe_n      <= !(nxt_state == msd_pkg::MSD_STRB && tgt_ff == msd_pkg::MSD_TGT_EXT); // RL8 RL10
    end
  end

  // direction, space select and high address byte
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_wr_n       <= 1'b1;
      prog_data_sel <= `MSD_SEL_PROG;
      addr_hi       <= 8'h00;
    end else begin
      rd_wr_n       <= !((nxt_state == msd_pkg::MSD_ADDR || nxt_state == msd_pkg::MSD_STRB) && nxt_write); // RL9
      prog_data_sel <= nxt_prog ? `MSD_SEL_PROG : ~`MSD_SEL_PROG; // RL6
      addr_hi       <= nxt_addr[15:8]; // RL5
    end
  end

  // port 0: low address, then write data, else released
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ad_out  <= 8'h00;
      ad_oe_n <= 8'hff;
    end else if (nxt_state == msd_pkg::MSD_ADDR) begin
      ad_out  <= nxt_addr[7:0]; // RL5
      ad_oe_n <= 8'h00;
    end else if (nxt_state == msd_pkg::MSD_STRB && write_ff && tgt_ff == msd_pkg::MSD_TGT_EXT) begin
      ad_out  <= wdata_ff; // RL5
      ad_oe_n <= 8'h00;
    end else begin
      ad_oe_n <= 8'hff;
    end
  end

  // on-chip memory ports during strobe phase
  // enable in the last strobe cycle, read data back one cycle later
  always_comb begin
    nvm_en    = (state_ff == msd_pkg::MSD_STRB) && (tgt_ff == msd_pkg::MSD_TGT_NVM) && phase_end; // RL3
    nvm_we    = nvm_en & write_ff;
    nvm_addr  = addr_ff[8:0];
    nvm_wdata = wdata_ff;
    ram_en    = (state_ff == msd_pkg::MSD_STRB) && (tgt_ff == msd_pkg::MSD_TGT_RAM) && phase_end; // RL4
    ram_we    = ram_en & write_ff;
    ram_addr  = addr_ff[7:0];
    ram_wdata = wdata_ff;
  end

  // answer to the core
  // external read data is the pin value seen one edge into the strobe phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= (state_ff == msd_pkg::MSD_DONE);
      if (state_ff == msd_pkg::MSD_DONE && !write_ff) begin
        case (tgt_ff)
          msd_pkg::MSD_TGT_NVM: rsp_rdata <= nvm_rdata;
          msd_pkg::MSD_TGT_RAM: rsp_rdata <= ram_rdata;
          default:              rsp_rdata <= ad_sync2_ff;
        endcase
      end
    end
  end
endmodule : msd_memory_space_decoder

// ---- hw/msd_pkg.sv ----
package msd_pkg;
  typedef enum logic [1:0] {
    MSD_TGT_EXT = 2'h0,
    MSD_TGT_NVM = 2'h1,
    MSD_TGT_RAM = 2'h2
  } msd_tgt_t;
  typedef enum logic [3:0] {
    MSD_IDLE = 4'h1,
    MSD_ADDR = 4'h2,
    MSD_STRB = 4'h4,
    MSD_DONE = 4'h8
  } msd_state_t;
endpackage : msd_pkg

// ---- hw/msd_target_decode.sv ----
`timescale 1ns/1ps
`include "msd_map.svh"
module msd_target_decode (
  // access request
  input  wire logic              is_prog,
  input  wire logic [15:0]       addr,
  // selected target
  output msd_pkg::msd_tgt_t      tgt
);
  // program always external, data windows below 300h internal
  always_comb begin
    if (is_prog) begin
      tgt = msd_pkg::MSD_TGT_EXT; // RL2
    end else if (addr <= `MSD_NVM_LAST) begin
      tgt = msd_pkg::MSD_TGT_NVM; // RL3
    end else if (addr <= `MSD_RAM_LAST) begin
      tgt = msd_pkg::MSD_TGT_RAM; // RL4
    end else begin
      tgt = msd_pkg::MSD_TGT_EXT; // RL10
    end
  end
endmodule : msd_target_decode

// ---- tb/msd_chk.sv ----
`timescale 1ns/1ps
module msd_chk (
  // core side
  input wire logic        sys_clk, rstn, req_valid, req_ready, req_prog, req_write, rsp_valid,
  input wire logic [15:0] req_addr,
  // memory side
  input wire logic        nvm_en, ram_en, address_latch_strobe_n, transfer_strobe_n, rd_wr_n, prog_data_sel,
  input wire logic [7:0]  ad_out, ad_oe_n, addr_hi
);
  logic tk, ext, nvm, ram;
  // taken request and its target
  assign tk  = req_valid && req_ready;
  assign nvm = !req_prog && req_addr[15:9] == 7'h00;
  assign ram = !req_prog && req_addr[15:8] == 8'h02;
  assign ext = !nvm && !ram;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  property p_als; tk |=> !address_latch_strobe_n[*2] ##1 address_latch_strobe_n; endproperty
  a_als: assert property (p_als) else $error("address strobe not low two cycles");
  property p_once; $fell(address_latch_strobe_n) |=> !address_latch_strobe_n ##1 address_latch_strobe_n[*4]; endproperty
  a_once: assert property (p_once) else $error("address strobe pulsed twice");
  property p_nvm; tk && nvm |-> ##4 nvm_en && !ram_en; endproperty
  a_nvm: assert property (p_nvm) else $error("nonvolatile memory not selected");
  property p_ram; tk && ram |-> ##4 ram_en && !nvm_en; endproperty
  a_ram: assert property (p_ram) else $error("ram not selected");
  property p_ds; tk && !ext |=> transfer_strobe_n[*5]; endproperty
  a_ds: assert property (p_ds) else $error("transfer strobe on on-chip access");
  property p_ext; tk && ext |-> ##3 !transfer_strobe_n[*2] ##1 transfer_strobe_n; endproperty
  a_ext: assert property (p_ext) else $error("external strobe sequence wrong");
  property p_adr; tk && ext |=> ad_out == $past(req_addr[7:0]) && addr_hi == $past(req_addr[15:8]) && ad_oe_n == 8'h00; endproperty
  a_adr: assert property (p_adr) else $error("external address wrong");
  property p_rw; tk |=> rd_wr_n == !$past(req_write); endproperty
  a_rw: assert property (p_rw) else $error("direction wrong");
  property p_sel; tk |=> prog_data_sel == $past(req_prog); endproperty
  a_sel: assert property (p_sel) else $error("space select wrong");
  property p_rel; tk && ext && !req_write |-> ##3 (ad_oe_n == 8'hff)[*2]; endproperty
  a_rel: assert property (p_rel) else $error("port 0 not released for read");
endmodule : msd_chk
bind msd_memory_space_decoder msd_chk u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req_prog(req_prog),
  .req_write(req_write), .rsp_valid(rsp_valid), .req_addr(req_addr), .nvm_en(nvm_en), .ram_en(ram_en),
  .address_latch_strobe_n(address_latch_strobe_n), .transfer_strobe_n(transfer_strobe_n), .rd_wr_n(rd_wr_n),
  .prog_data_sel(prog_data_sel), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .addr_hi(addr_hi)
);

// ---- tb/msd_ext_mem.sv ----
`timescale 1ns/1ps
module msd_ext_mem (
  // sampling clock
  input wire logic       sys_clk,
  // strobes and address
  input wire logic       address_latch_strobe_n, transfer_strobe_n, rd_wr_n, prog_data_sel,
  input wire logic [7:0] ad_out, ad_oe_n, addr_hi,
  // read data to the port
  output logic [7:0]     ad_in
);
  logic [7:0]  mem [0:131071];
  logic [16:0] a_ff;
  // latch follows the pins while the strobe is low, holds from its rise
  always_ff @(posedge sys_clk) if (!address_latch_strobe_n) a_ff <= {prog_data_sel, addr_hi, ad_out};
  // write data taken while strobe low and port driven
  always_ff @(posedge sys_clk) if (!transfer_strobe_n && !rd_wr_n && ad_oe_n == 8'h00) mem[a_ff] <= ad_out;
  // port shows inverted data except while strobe low on a read
  assign ad_in = (!transfer_strobe_n && rd_wr_n) ? mem[a_ff] : ~mem[a_ff];
endmodule : msd_ext_mem

// ---- tb/test_memory_space_decoder.sv ----
`timescale 1ns/1ps
module test_memory_space_decoder;
  logic        sys_clk = 0, rstn = 0, req_valid = 0, req_prog = 0, req_write = 0;
  logic [15:0] req_addr = 0;
  logic [7:0]  req_wdata = 0, nvm_rdata = 0, ram_rdata = 0;
  logic        req_ready, rsp_valid, nvm_en, nvm_we, ram_en, ram_we, prog_data_sel;
  logic        address_latch_strobe_n, transfer_strobe_n, rd_wr_n;
  logic [7:0]  rsp_rdata, ram_addr, nvm_wdata, ram_wdata, ad_in, ad_out, ad_oe_n, addr_hi;
  logic [8:0]  nvm_addr;
  logic [7:0]  nvm [0:511];
  logic [7:0]  ram [0:255];
  int          n_fail = 0, n_checks = 0, nds, nen, i;
  msd_memory_space_decoder dut (
    .sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req_ready(req_ready), .req_prog(req_prog),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .nvm_en(nvm_en), .nvm_we(nvm_we), .nvm_addr(nvm_addr), .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata), .ram_en(ram_en), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_rdata(ram_rdata), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .addr_hi(addr_hi),
    .address_latch_strobe_n(address_latch_strobe_n), .transfer_strobe_n(transfer_strobe_n),
    .rd_wr_n(rd_wr_n), .prog_data_sel(prog_data_sel)
  );
  msd_ext_mem ext (
    .sys_clk(sys_clk), .address_latch_strobe_n(address_latch_strobe_n), .transfer_strobe_n(transfer_strobe_n),
    .rd_wr_n(rd_wr_n), .prog_data_sel(prog_data_sel), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .addr_hi(addr_hi),
    .ad_in(ad_in)
  );
  initial forever #25 sys_clk = ~sys_clk;
  // on-chip memories, one cycle read latency
  always @(posedge sys_clk) begin
    if (nvm_en && nvm_we) nvm[nvm_addr] <= nvm_wdata;
    if (ram_en && ram_we) ram[ram_addr] <= ram_wdata;
    nvm_rdata <= #5 nvm[nvm_addr];
    ram_rdata <= #5 ram[ram_addr];
  end
  task chk(string what, logic [7:0] seen, logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  // one access; xen 1 for nvm, 2 for ram, xds strobe cycles
  task acc(logic p, logic w, logic [15:0] a, logic [7:0] d, int xds, int xen, logic [7:0] xrd);
    {req_prog, req_write, req_addr, req_wdata, req_valid} = {p, w, a, d, 1'b1};
    nds = 0;
    nen = 0;
    @(posedge sys_clk) #5 req_valid = 0;
    chk("ready while busy", {7'h00, req_ready}, 8'h00);
    for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) begin
      @(posedge sys_clk) #5;
      nds += (transfer_strobe_n === 1'b0);
      nen += (nvm_en === 1'b1) + 2 * (ram_en === 1'b1);
    end
    if (i == 20) begin
      n_fail++;
      end_sim;
    end
    // answer shows right after the fifth edge past the take
    chk("latency", 8'(i), 8'h05);
    chk("strobe cycles", 8'(nds), 8'(xds));
    chk("on-chip target", 8'(nen), 8'(xen));
    if (!w) chk("read data", rsp_rdata, xrd);
  endtask : acc
  task t_onchip;
    acc(0, 1, 16'h0000, 8'h5a, 0, 1, 0);
    acc(0, 1, 16'h01ff, 8'ha5, 0, 1, 0);
    acc(0, 1, 16'h0200, 8'h3c, 0, 2, 0);
    acc(0, 1, 16'h02ff, 8'hc3, 0, 2, 0);
    acc(0, 0, 16'h0000, 0, 0, 1, 8'h5a);
    acc(0, 0, 16'h01ff, 0, 0, 1, 8'ha5);
    acc(0, 0, 16'h0200, 0, 0, 2, 8'h3c);
    acc(0, 0, 16'h02ff, 0, 0, 2, 8'hc3);
    $display("on-chip test done");
  endtask : t_onchip
  task t_ext;
    acc(0, 1, 16'h0300, 8'h11, 2, 0, 0);
    acc(1, 1, 16'h0300, 8'h22, 2, 0, 0);
    acc(1, 1, 16'h0000, 8'h33, 2, 0, 0);
    acc(0, 1, 16'hffff, 8'h44, 2, 0, 0);
    acc(0, 0, 16'h0300, 0, 2, 0, 8'h11);
    acc(1, 0, 16'h0300, 0, 2, 0, 8'h22);
    acc(1, 0, 16'h0000, 0, 2, 0, 8'h33);
    acc(0, 0, 16'hffff, 0, 2, 0, 8'h44);
    $display("external test done");
  endtask : t_ext
  initial begin
    repeat (3) @(posedge sys_clk);
    #5 rstn = 1;
    t_onchip;
    t_ext;
    end_sim;
  end
endmodule : test_memory_space_decoder
